// file: core/pmic_mask_consts.svh
// Constants of the interrupt mask bank
`ifndef PMIC_MASK_CONSTS_SVH
`define PMIC_MASK_CONSTS_SVH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define IDX_PWR_MASK      16'h401a
`define IDX_LDO_MASK      16'h401b
`define IDX_DC_MASK       16'h401c
`define IDX_PWR_STATUS    16'h4012
`define IDX_LDO_STATUS    16'h4013
`define IDX_DC_STATUS     16'h4014
`define IDX_LSB_PAD       2'b00

// ****************************************************************
// Implemented bit positions of each word
// ****************************************************************
`define PWR_VALID         16'h0037
`define LDO_VALID         16'h03ff
`define DC_VALID          16'h038f

// ****************************************************************
// Reset values
// ****************************************************************
`define MASK_PWR_RESET    16'h0037
`define MASK_LDO_RESET    16'h03ff
`define MASK_DC_RESET     16'h038f
`define STATUS_RESET      16'h0000
`define WORD_ZERO         16'h0000
`define BUS_ZERO          32'h0000_0000

`endif

// file: core/pmic_mask_pkg.sv
// Types of the interrupt mask bank
package pmic_mask_pkg;

	// ****************************************************************
	// Word layouts
	// ****************************************************************
	typedef struct packed {
		logic [15:6] unused_hi;
		logic        cfgmem_cmd_done_mask;
		logic        cfgmem_error_mask;
		logic        unused_3;
		logic        power_on_reset_state_mask;
		logic        sleep_off_transition_mask;
		logic        on_wake_transition_mask;
	} pwr_word_t;

	typedef struct packed {
		logic [15:10] unused_hi;
		logic         regulator10_undervoltage_mask;
		logic [8:1]   regulator9_2_undervoltage_mask;
		logic         regulator1_undervoltage_mask;
	} ldo_word_t;

	typedef struct packed {
		logic [15:10] unused_hi;
		logic         converter2_high_current_mask;
		logic         converter1_high_current_mask;
		logic         crystal_start_mask;
		logic [6:4]   unused_mid;
		logic         converter4_undervoltage_mask;
		logic [2:1]   converter3_2_undervoltage_mask;
		logic         converter1_undervoltage_mask;
	} dc_word_t;

	// One-cycle event pulses from the sources, same layout as the masks
	typedef struct packed {
		pwr_word_t pwr;
		ldo_word_t ldo;
		dc_word_t  dc;
	} event_set_t;

	// ****************************************************************
	// APB carriers
	// ****************************************************************
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [17:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef enum logic [2:0] {
		SEL_NONE       = 3'b000,
		SEL_PWR_MASK   = 3'b001,
		SEL_LDO_MASK   = 3'b010,
		SEL_DC_MASK    = 3'b011,
		SEL_PWR_STATUS = 3'b100,
		SEL_LDO_STATUS = 3'b101,
		SEL_DC_STATUS  = 3'b110
	} reg_sel_t;

endpackage

// file: core/event_latch.sv
// Sticky event flags with write-one-to-clear
`timescale 1ns/1ps
`include "pmic_mask_consts.svh"
module event_latch #(
	parameter int          W     = 16,
	parameter logic [15:0] VALID = 16'hffff
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] set_pulse,
	input  wire logic [W-1:0] clr_ones,
	output logic      [W-1:0] flags_r
);
	logic [W-1:0] flags_nxt;

	// ****************************************************************
	// Set wins over a clear in the same cycle
	// ****************************************************************
	always_comb begin
		flags_nxt = ((flags_r & ~clr_ones) | set_pulse) & VALID[W-1:0];
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_r <= `STATUS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end
endmodule // event_latch

// file: core/pmic_interrupt_mask_bank.sv
// Interrupt mask bank with status flags on an APB slave
`timescale 1ns/1ps
`include "pmic_mask_consts.svh"
module pmic_interrupt_mask_bank (
	input  wire logic                     core_clk,
	input  wire logic                     rst_b,
	input  wire pmic_mask_pkg::apb_req_t  apb_req,
	output pmic_mask_pkg::apb_rsp_t       apb_rsp,
	input  wire pmic_mask_pkg::event_set_t events,
	output logic                          irq
);
	import pmic_mask_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	pwr_word_t   pwr_mask_r;
	ldo_word_t   ldo_mask_r;
	dc_word_t    dc_mask_r;
	logic [15:0] pwr_status;
	logic [15:0] ldo_status;
	logic [15:0] dc_status;
	logic [15:0] pwr_clr;
	logic [15:0] ldo_clr;
	logic [15:0] dc_clr;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic        irq_r;
	logic        irq_nxt;
	logic        setup_phase;
	logic        wr_take;
	reg_sel_t    sel;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
		hit = (a == {idx, `IDX_LSB_PAD});
	endfunction

	function automatic reg_sel_t decode(input logic [17:0] a);
		if (hit(a, `IDX_PWR_MASK)) begin
			decode = SEL_PWR_MASK;
		end else if (hit(a, `IDX_LDO_MASK)) begin
			decode = SEL_LDO_MASK;
		end else if (hit(a, `IDX_DC_MASK)) begin
			decode = SEL_DC_MASK;
		end else if (hit(a, `IDX_PWR_STATUS)) begin
			decode = SEL_PWR_STATUS;
		end else if (hit(a, `IDX_LDO_STATUS)) begin
			decode = SEL_LDO_STATUS;
		end else if (hit(a, `IDX_DC_STATUS)) begin
			decode = SEL_DC_STATUS;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	assign sel         = decode(apb_req.paddr);
	assign setup_phase = apb_req.psel & ~apb_req.penable;
	assign wr_take     = apb_req.psel & apb_req.penable & apb_req.pwrite;

	// ****************************************************************
	// Mask registers
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_mask_r <= `MASK_PWR_RESET;
		end else if (wr_take && sel == SEL_PWR_MASK) begin
			pwr_mask_r <= apb_req.pwdata[15:0] & `PWR_VALID;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ldo_mask_r <= `MASK_LDO_RESET;
		end else if (wr_take && sel == SEL_LDO_MASK) begin
			ldo_mask_r <= apb_req.pwdata[15:0] & `LDO_VALID;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dc_mask_r <= `MASK_DC_RESET;
		end else if (wr_take && sel == SEL_DC_MASK) begin
			dc_mask_r <= apb_req.pwdata[15:0] & `DC_VALID;
		end
	end

	// ****************************************************************
	// Status flags, write one to clear
	// ****************************************************************
	always_comb begin
		pwr_clr = `WORD_ZERO;
		ldo_clr = `WORD_ZERO;
		dc_clr  = `WORD_ZERO;
		if (wr_take) begin
			case (sel)
				SEL_PWR_STATUS: begin
					pwr_clr = apb_req.pwdata[15:0];
				end
				SEL_LDO_STATUS: begin
					ldo_clr = apb_req.pwdata[15:0];
				end
				SEL_DC_STATUS: begin
					dc_clr = apb_req.pwdata[15:0];
				end
				default: begin
					pwr_clr = `WORD_ZERO;
				end
			endcase
		end
	end

	// Flags latch regardless of the masks
	event_latch #(
		.W     (16),
		.VALID (`PWR_VALID)
	) u_pwr_flags (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.set_pulse (events.pwr),
		.clr_ones  (pwr_clr),
		.flags_r   (pwr_status)
	);

	event_latch #(
		.W     (16),
		.VALID (`LDO_VALID)
	) u_ldo_flags (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.set_pulse (events.ldo),
		.clr_ones  (ldo_clr),
		.flags_r   (ldo_status)
	);

	event_latch #(
		.W     (16),
		.VALID (`DC_VALID)
	) u_dc_flags (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.set_pulse (events.dc),
		.clr_ones  (dc_clr),
		.flags_r   (dc_status)
	);

	// ****************************************************************
	// Combined interrupt
	// ****************************************************************
	always_comb begin
		irq_nxt = |(pwr_status & ~pwr_mask_r)
		        | |(ldo_status & ~ldo_mask_r)
		        | |(dc_status & ~dc_mask_r);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign irq = irq_r;

	// ****************************************************************
	// Read data, captured in the setup cycle
	// ****************************************************************
	always_comb begin
		prdata_nxt  = `BUS_ZERO;
		pslverr_nxt = 1'b0;
		case (sel)
			SEL_PWR_MASK: begin
				prdata_nxt[15:0] = pwr_mask_r;
			end
			SEL_LDO_MASK: begin
				prdata_nxt[15:0] = ldo_mask_r;
			end
			SEL_DC_MASK: begin
				prdata_nxt[15:0] = dc_mask_r;
			end
			SEL_PWR_STATUS: begin
				prdata_nxt[15:0] = pwr_status;
			end
			SEL_LDO_STATUS: begin
				prdata_nxt[15:0] = ldo_status;
			end
			SEL_DC_STATUS: begin
				prdata_nxt[15:0] = dc_status;
			end
			default: begin
				pslverr_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_r <= `BUS_ZERO;
		end else if (setup_phase) begin
			prdata_r <= apb_req.pwrite ? `BUS_ZERO : prdata_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pslverr_r <= 1'b0;
		end else if (setup_phase) begin
			pslverr_r <= pslverr_nxt;
		end
	end

	assign apb_rsp.pready  = apb_req.psel & apb_req.penable;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & pslverr_r;
	assign apb_rsp.prdata  = prdata_r;

endmodule // pmic_interrupt_mask_bank

// file: dv/pmic_mask_assertions.sv
// Checker of the interrupt mask bank
`timescale 1ns/1ps
`include "pmic_mask_consts.svh"
module pmic_mask_assertions (
	input wire logic                      core_clk,
	input wire logic                      rst_b,
	input wire pmic_mask_pkg::apb_req_t   apb_req,
	input wire pmic_mask_pkg::apb_rsp_t   apb_rsp,
	input wire pmic_mask_pkg::event_set_t events,
	input wire logic                      irq
);
	import pmic_mask_pkg::*;
	// ****
	// Shadow masks
	// ****
	localparam logic [15:0] VLD [3] = '{`PWR_VALID, `LDO_VALID, `DC_VALID};
	logic [15:0] m_r [3];
	logic [1:0]  sel;
	logic        acc;
	logic        wr_m;
	logic        all_m;
	assign acc = apb_req.psel & apb_req.penable;
	assign wr_m = acc & apb_req.pwrite & (sel != 2'd3);
	assign all_m = {m_r[0], m_r[1], m_r[2]} == {VLD[0], VLD[1], VLD[2]};
	always_comb begin
		case (apb_req.paddr)
			{`IDX_PWR_MASK, `IDX_LSB_PAD}: sel = 2'd0;
			{`IDX_LDO_MASK, `IDX_LSB_PAD}: sel = 2'd1;
			{`IDX_DC_MASK, `IDX_LSB_PAD}: sel = 2'd2;
			default: sel = 2'd3;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			m_r <= VLD;
		end else if (wr_m) begin
			m_r[sel] <= apb_req.pwdata[15:0] & VLD[sel];
		end
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_hit;
		(|(events & ~{m_r[0], m_r[1], m_r[2]} & {VLD[0], VLD[1], VLD[2]}))
			&& !wr_m;
	endsequence
	property p_rb(int w);
		acc && !apb_req.pwrite && sel == w
			|-> apb_rsp.prdata == {16'h0, m_r[w]};
	endproperty
	a_irq_unmasked: assert property (s_hit |=> ##1 irq)
		else $error("irq missing after unmasked event");
	a_irq_blocked: assert property ($past(all_m) |-> !irq)
		else $error("irq while all masked");
	a_pwr_readback: assert property (p_rb(0))
		else $error("power mask readback wrong");
	a_ldo_readback: assert property (p_rb(1))
		else $error("regulator mask readback wrong");
	a_dc_readback: assert property (p_rb(2))
		else $error("converter mask readback wrong");
	a_upper_zero: assert property (acc |-> apb_rsp.prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_irq_after_reset: assert property ($rose(rst_b) |-> !irq)
		else $error("irq high right after reset release");
endmodule // pmic_mask_assertions

bind pmic_interrupt_mask_bank pmic_mask_assertions i_pmic_mask_assertions (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.apb_req(apb_req),
	.apb_rsp(apb_rsp),
	.events(events),
	.irq(irq)
);

// file: dv/tb_pmic_interrupt_mask_bank.sv
// Testbench of the interrupt mask bank
`timescale 1ns/1ps
`include "pmic_mask_consts.svh"
module tb_pmic_interrupt_mask_bank;
	import pmic_mask_pkg::*;
	logic        core_clk;
	logic        rst_b;
	apb_req_t    apb_req;
	apb_rsp_t    apb_rsp;
	event_set_t  events;
	logic        irq;
	int          mismatches;
	int          comparisons;
	int          cyc;
	logic [31:0] rd;
	logic        err;
	logic [17:0] ma [3];
	logic [17:0] sa [3];
	logic [15:0] va [3];
	logic [15:0] rv [3];
	pmic_interrupt_mask_bank i_pmic_interrupt_mask_bank (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.events(events),
		.irq(irq)
	);
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	// ****
	// Helpers
	// ****
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [17:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	task automatic settle();
		@(posedge core_clk);
		#1;
	endtask
	task automatic pulse(input logic [47:0] x);
		@(posedge core_clk);
		events <= x;
		@(posedge core_clk);
		events <= '0;
		settle();
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		for (int w = 0; w < 3; w++) begin
			apb(1'b0, ma[w], '0);
			chk(rd, {16'h0, rv[w]});
			chk(32'(err), 32'h0);
		end
		chk(32'(irq), 32'h0);
	endtask
	task automatic t_rw();
		for (int w = 0; w < 3; w++) begin
			apb(1'b1, ma[w], 32'hffff_ffff);
			apb(1'b0, ma[w], '0);
			chk(rd, {16'h0, va[w]});
			apb(1'b1, ma[w], '0);
			apb(1'b0, ma[w], '0);
			chk(rd, 32'h0);
			apb(1'b1, ma[w], {16'h0, va[w]});
		end
	endtask
	task automatic t_bits();
		logic [15:0] b1;
		for (int w = 0; w < 3; w++) begin
			for (int b = 0; b < 16; b++) begin
				b1 = 16'h1 << b;
				if (va[w][b]) begin
					pulse(48'h1 << (16 * (2 - w) + b));
					chk(32'(irq), 32'h0);
					apb(1'b0, sa[w], '0);
					chk(rd, {16'h0, b1});
					apb(1'b1, ma[w], {16'h0, va[w] & ~b1});
					settle();
					chk(32'(irq), 32'h1);
					apb(1'b1, sa[w], {16'h0, b1});
					settle();
					chk(32'(irq), 32'h0);
					pulse(48'h1 << (16 * (2 - w) + b));
					chk(32'(irq), 32'h1);
					apb(1'b1, sa[w], {16'h0, b1});
					apb(1'b1, ma[w], {16'h0, va[w]});
					settle();
					chk(32'(irq), 32'h0);
				end
			end
		end
	endtask
	task automatic t_unmapped();
		apb(1'b1, 18'h0, 32'hffff_ffff);
		chk(32'(err), 32'h1);
		apb(1'b0, 18'h0, '0);
		chk({rd[31:1], err}, 32'h1);
	endtask
	task automatic t_midreset();
		apb(1'b1, ma[0], {16'h0, va[0] & ~16'h1});
		pulse(48'h1 << 32);
		chk(32'(irq), 32'h1);
		@(posedge core_clk);
		rst_b <= 1'b0;
		settle();
		chk(32'(irq), 32'h0);
		@(posedge core_clk);
		rst_b <= 1'b1;
		apb(1'b0, sa[0], '0);
		chk(rd, 32'h0);
		t_reset();
	endtask
	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		apb_req = '0;
		events = '0;
		mismatches = 0;
		comparisons = 0;
		cyc = 0;
		ma = '{{`IDX_PWR_MASK, `IDX_LSB_PAD}, {`IDX_LDO_MASK, `IDX_LSB_PAD},
			{`IDX_DC_MASK, `IDX_LSB_PAD}};
		sa = '{{`IDX_PWR_STATUS, `IDX_LSB_PAD},
			{`IDX_LDO_STATUS, `IDX_LSB_PAD}, {`IDX_DC_STATUS, `IDX_LSB_PAD}};
		va = '{`PWR_VALID, `LDO_VALID, `DC_VALID};
		rv = '{`MASK_PWR_RESET, `MASK_LDO_RESET, `MASK_DC_RESET};
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset();
		t_rw();
		t_bits();
		t_unmapped();
		t_midreset();
		summarize();
	end
endmodule // tb_pmic_interrupt_mask_bank
